// ---- pkg/stf_pkg.sv ----
// Package for the status transition filter bank
package stf_pkg;
  // ----------------------------------------
  // Widths and group selection
  // ----------------------------------------
  localparam int STF_WIDTH = 16;
  localparam logic [1:0] STF_GRP_OPERATION = 2'h0;
  localparam logic [1:0] STF_GRP_TRIGGER = 2'h1;
  localparam logic [1:0] STF_GRP_ARM = 2'h2;
  localparam logic [1:0] STF_GRP_SEQUENCE = 2'h3;
  localparam logic [2:0] STF_REG_RISE = 3'h0;
  localparam logic [2:0] STF_REG_FALL = 3'h1;
  localparam logic [2:0] STF_REG_EVENT = 3'h2;
  localparam logic [2:0] STF_REG_COND = 3'h3;
  localparam logic [15:0] STF_RESET_VALUE = 16'h0000;

  // ----------------------------------------
  // Valid bit masks of each group
  // ----------------------------------------
  // Operation: idle b10, calculating b9, arm b6, trigger b5, settling b1, calibrating b0
  localparam logic [15:0] STF_MASK_OPERATION = 16'h0663;
  localparam logic [15:0] STF_MASK_TRIGGER = 16'h0002;
  localparam logic [15:0] STF_MASK_ARM = 16'h0002;
  localparam logic [15:0] STF_MASK_SEQUENCE = 16'h0006;
  localparam int STF_OP_CALIBRATING = 0;
  localparam int STF_OP_SETTLING = 1;
  localparam int STF_OP_TRIGGER_LAYER = 5;
  localparam int STF_OP_ARM_LAYER = 6;
  localparam int STF_OP_CALCULATING = 9;
  localparam int STF_OP_IDLE = 10;
  localparam int STF_TRIG_SEQUENCE_ONE = 1;
  localparam int STF_ARM_SEQUENCE_ONE = 1;
  localparam int STF_SEQ_ARM_LAYER_ONE = 1;
  localparam int STF_SEQ_ARM_LAYER_TWO = 2;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] riseEnable;
    logic [15:0] fallEnable;
    logic [15:0] condPrev;
    logic [15:0] eventBits;
  } stf_group_t;

  typedef struct packed {
    logic calibrating;
    logic settling;
    logic triggerLayer;
    logic armLayer;
    logic calculating;
    logic idle;
    logic trigSequenceOne;
    logic armSequenceOne;
    logic armLayerOne;
    logic armLayerTwo;
  } stf_cond_t;

  typedef struct packed {
    logic write;
    logic read;
    logic clearEvents;
    logic preset;
    logic [1:0] group;
    logic [2:0] register;
    logic [15:0] data;
  } stf_req_t;

  typedef struct packed {
    stf_group_t [3:0] groups;
    logic readValid;
    logic [15:0] readData;
  } stf_state_t;
endpackage : stf_pkg

// ---- logic/stf_transition_filters.sv ----
// Transition filters for operation, trigger, arm and sequence event groups
`timescale 1ns/10ps
// Contract
// RULE1: Operation bits: idle10 calc9 arm6 trig5 set1 cal0
// RULE2: Rise enable one passes, zero blocks
// RULE3: Fall enable one passes, zero blocks
// RULE4: Trigger bit1: sequence one waits trigger
// RULE5: Arm bit1: sequence one in arm
// RULE6: Sequence bit1: arm layer one entered
// RULE7: Sequence bit2: arm layer two entered
// RULE8: Values are binary weight sums
// RULE9: Rise is zero to one versus previous
// RULE10: Fall is one to zero versus previous
// RULE11: Operation conditions rise at listed points
// RULE12: Event bits stick until software clears
module stf_transition_filters
  import stf_pkg::*;
#(
  parameter int WIDTH = STF_WIDTH
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Condition inputs
  input wire stf_cond_t cond,
  // Command port
  input wire stf_req_t req,
  // Read answer
  output logic readValid,
  output logic [WIDTH-1:0] readData,
  // Event registers
  output logic [WIDTH-1:0] operationEvents,
  output logic [WIDTH-1:0] triggerEvents,
  output logic [WIDTH-1:0] armEvents,
  output logic [WIDTH-1:0] sequenceEvents
);

  // ----------------------------------------
  // Condition vectors
  // ----------------------------------------
  stf_state_t state;
  stf_state_t next_state;
  logic [3:0][15:0] condNow;
  logic [3:0][15:0] groupMask;

  always_comb
  begin
    condNow = '0;
    // RULE1: operation bit map
    // RULE11: operation rise points
    condNow[STF_GRP_OPERATION][STF_OP_CALIBRATING] = cond.calibrating;
    condNow[STF_GRP_OPERATION][STF_OP_SETTLING] = cond.settling;
    condNow[STF_GRP_OPERATION][STF_OP_TRIGGER_LAYER] = cond.triggerLayer;
    condNow[STF_GRP_OPERATION][STF_OP_ARM_LAYER] = cond.armLayer;
    condNow[STF_GRP_OPERATION][STF_OP_CALCULATING] = cond.calculating;
    condNow[STF_GRP_OPERATION][STF_OP_IDLE] = cond.idle;
    // RULE4: trigger sequence one
    condNow[STF_GRP_TRIGGER][STF_TRIG_SEQUENCE_ONE] = cond.trigSequenceOne;
    // RULE5: arm sequence one
    condNow[STF_GRP_ARM][STF_ARM_SEQUENCE_ONE] = cond.armSequenceOne;
    // RULE6: arm layer one
    condNow[STF_GRP_SEQUENCE][STF_SEQ_ARM_LAYER_ONE] = cond.armLayerOne;
    // RULE7: arm layer two
    condNow[STF_GRP_SEQUENCE][STF_SEQ_ARM_LAYER_TWO] = cond.armLayerTwo;
  end

  always_comb
  begin
    groupMask[STF_GRP_OPERATION] = STF_MASK_OPERATION;
    groupMask[STF_GRP_TRIGGER] = STF_MASK_TRIGGER;
    groupMask[STF_GRP_ARM] = STF_MASK_ARM;
    groupMask[STF_GRP_SEQUENCE] = STF_MASK_SEQUENCE;
  end

  // ----------------------------------------
  // Per-group filter logic
  // ----------------------------------------
  logic [3:0][15:0] riseSeen;
  logic [3:0][15:0] fallSeen;
  logic [3:0][15:0] eventSet;

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : gen_group
      // RULE9: rise against previous
      assign riseSeen[g] = condNow[g] & ~state.groups[g].condPrev;
      // RULE10: fall against previous
      assign fallSeen[g] = ~condNow[g] & state.groups[g].condPrev;
      // RULE2: rise enable gate
      // RULE3: fall enable gate
      assign eventSet[g] = ((riseSeen[g] & state.groups[g].riseEnable) |
                            (fallSeen[g] & state.groups[g].fallEnable)) & groupMask[g];
    end
  endgenerate

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    next_state = state;
    next_state.readValid = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      next_state.groups[i].condPrev = condNow[i];
      if (req.preset)
      begin
        next_state.groups[i].riseEnable = STF_RESET_VALUE;
        next_state.groups[i].fallEnable = STF_RESET_VALUE;
      end
      if (req.clearEvents)
      begin
        next_state.groups[i].eventBits = STF_RESET_VALUE;
      end
    end
    // RULE8: weighted value write
    if (req.write && !req.preset)
    begin
      if (req.register == STF_REG_RISE)
      begin
        next_state.groups[req.group].riseEnable = req.data & groupMask[req.group];
      end
      else if (req.register == STF_REG_FALL)
      begin
        next_state.groups[req.group].fallEnable = req.data & groupMask[req.group];
      end
      else if (req.register == STF_REG_EVENT)
      begin
        next_state.groups[req.group].eventBits = state.groups[req.group].eventBits & ~req.data;
      end
    end
    // RULE12: sticky set beats clear
    for (int i = 0; i < 4; i++)
    begin
      next_state.groups[i].eventBits = next_state.groups[i].eventBits | eventSet[i];
    end
    if (req.read)
    begin
      next_state.readValid = 1'b1;
      case (req.register)
        STF_REG_RISE: next_state.readData = state.groups[req.group].riseEnable;
        STF_REG_FALL: next_state.readData = state.groups[req.group].fallEnable;
        STF_REG_EVENT: next_state.readData = state.groups[req.group].eventBits;
        STF_REG_COND: next_state.readData = condNow[req.group];
        default: next_state.readData = STF_RESET_VALUE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign readValid = state.readValid;
  assign readData = state.readData;
  assign operationEvents = state.groups[STF_GRP_OPERATION].eventBits;
  assign triggerEvents = state.groups[STF_GRP_TRIGGER].eventBits;
  assign armEvents = state.groups[STF_GRP_ARM].eventBits;
  assign sequenceEvents = state.groups[STF_GRP_SEQUENCE].eventBits;

endmodule : stf_transition_filters

// ---- dv/stf_transition_filters_properties.sv ----
// Checker for the status transition filter bank
`timescale 1ns/10ps
module stf_transition_filters_properties
  import stf_pkg::*;
#(
  parameter int WIDTH = STF_WIDTH
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Requests
  input wire stf_cond_t cond,
  input wire stf_req_t req,
  // Answers
  input wire logic readValid,
  input wire logic [WIDTH-1:0] readData,
  input wire logic [WIDTH-1:0] operationEvents,
  input wire logic [WIDTH-1:0] triggerEvents,
  input wire logic [WIDTH-1:0] armEvents,
  input wire logic [WIDTH-1:0] sequenceEvents
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ----
  // Properties
  // ----
  a_read_answer_next: assert property (req.read |=> readValid)
    else $error("read not answered");
  a_valid_one_pulse: assert property (!req.read |=> !readValid)
    else $error("stray read valid");
  a_operation_bits_used: assert property ((operationEvents & ~16'h0663) == 16'h0000)
    else $error("unused operation bit set");
  a_trigger_bits_used: assert property ((triggerEvents & ~16'h0002) == 16'h0000)
    else $error("unused trigger bit set");
  a_arm_bits_used: assert property ((armEvents & ~16'h0002) == 16'h0000)
    else $error("unused arm bit set");
  a_sequence_bits_used: assert property ((sequenceEvents & ~16'h0006) == 16'h0000)
    else $error("unused sequence bit set");
  a_events_stay_set: assert property (!$past(req.clearEvents) && !($past(req.write) && $past(req.register) == 3'h2)
    |-> ($past(operationEvents) & ~operationEvents) == 16'h0000) else $error("event bit lost");
  a_layer_cond_readback: assert property (req.read && req.group == 2'h3 && req.register == 3'h3
    |=> readData == {13'h0, $past(cond.armLayerTwo), $past(cond.armLayerOne), 1'b0}) else $error("bad condition read");
  a_unmapped_read_zero: assert property (req.read && req.register[2] |=> readData == 16'h0000)
    else $error("unmapped read not zero");
  cover property (readValid);
  cover property ($rose(operationEvents[10]));
  cover property ($rose(sequenceEvents[2]));
  cover property (req.preset && req.write);
endmodule : stf_transition_filters_properties

bind stf_transition_filters stf_transition_filters_properties #(.WIDTH(WIDTH)) i_props (.clk(clk), .reset(reset),
  .cond(cond), .req(req), .readValid(readValid), .readData(readData), .operationEvents(operationEvents),
  .triggerEvents(triggerEvents), .armEvents(armEvents), .sequenceEvents(sequenceEvents));

// ---- dv/stf_transition_filters_tb.sv ----
// Self-checking bench for the status transition filter bank
`timescale 1ns/10ps
module stf_transition_filters_tb;
  import stf_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  stf_cond_t cond = '0;
  stf_req_t req = '0;
  logic readValid;
  logic [15:0] readData, opEv, trEv, arEv, sqEv;
  int badCount = 0;
  int testsRun = 0;
  always #12.5 clk = ~clk;
  stf_transition_filters i_dut (.clk(clk), .reset(reset), .cond(cond), .req(req), .readValid(readValid),
    .readData(readData), .operationEvents(opEv), .triggerEvents(trEv), .armEvents(arEv), .sequenceEvents(sqEv));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    testsRun++;
    if (got !== exp)
    begin
      badCount++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic wr(input logic [1:0] g, input logic [2:0] r, input logic [15:0] d);
    req = '{1'b1, 1'b0, 1'b0, 1'b0, g, r, d};
    tick(1);
    req = '0;
    tick(1);
  endtask : wr
  task automatic rd(input logic [1:0] g, input logic [2:0] r, input logic [15:0] exp);
    req = '{1'b0, 1'b1, 1'b0, 1'b0, g, r, 16'h0000};
    tick(1);
    req = '0;
    check("readValid", 16'h0001, {15'h0000, readValid});
    check("readData", exp, readData);
    tick(1);
  endtask : rd
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test
  initial
  begin
    #50000;
    badCount++;
    end_of_test();
  end
  initial
  begin
    tick(4);
    reset = 1'b0;
    rd(2'h0, 3'h0, 16'h0000);
    wr(2'h0, 3'h0, 16'h0402);
    rd(2'h0, 3'h0, 16'h0402);
    wr(2'h0, 3'h0, 16'hFFFF);
    rd(2'h0, 3'h0, 16'h0663);
    rd(2'h3, 3'h4, 16'h0000);
    $display("test registers done");
    cond = 10'h3F0;
    tick(2);
    check("operationEvents", 16'h0663, opEv);
    cond = '0;
    tick(2);
    check("operationEvents", 16'h0663, opEv);
    wr(2'h0, 3'h2, 16'hFFFF);
    check("operationEvents", 16'h0000, opEv);
    wr(2'h0, 3'h1, 16'h0663);
    wr(2'h0, 3'h0, 16'h0000);
    cond = 10'h3F0;
    tick(2);
    check("operationEvents", 16'h0000, opEv);
    cond = '0;
    tick(2);
    check("operationEvents", 16'h0663, opEv);
    $display("test operation done");
    for (int g = 1; g < 4; g++)
      wr(2'(g), 3'h0, 16'hFFFF);
    cond = 10'h00F;
    tick(2);
    check("triggerEvents", 16'h0002, trEv);
    check("armEvents", 16'h0002, arEv);
    check("sequenceEvents", 16'h0006, sqEv);
    rd(2'h3, 3'h3, 16'h0006);
    rd(2'h1, 3'h2, 16'h0002);
    req = '{1'b1, 1'b0, 1'b0, 1'b1, 2'h1, 3'h0, 16'hFFFF};
    tick(1);
    req = '0;
    tick(1);
    rd(2'h1, 3'h0, 16'h0000);
    rd(2'h0, 3'h1, 16'h0000);
    req.clearEvents = 1'b1;
    tick(1);
    req = '0;
    tick(1);
    check("sequenceEvents", 16'h0000, sqEv);
    $display("test groups done");
    end_of_test();
  end
endmodule : stf_transition_filters_tb
